/* File: common/erm_cfg.svh */
// Purpose: offsets, field positions, reset values for the event request and mask block
// Assumes: byte addresses on both register ports, 12 bits wide
// Notes: definitions only
`ifndef ERM_CFG_SVH
`define ERM_CFG_SVH

// own registers
`define ERM_NET_MASK_OFS 12'h200
`define ERM_APP_MASK_OFS 12'h204
`define ERM_NET_REQ_OFS 12'h210
`define ERM_APP_REQ_OFS 12'h220

// source registers whose access clears a flag
`define ERM_LINK_STAT_LO 12'h110
`define ERM_LINK_STAT_HI 12'h111
`define ERM_APP_CTRL_LO 12'h120
`define ERM_APP_CTRL_HI 12'h121
`define ERM_APP_STAT_LO 12'h130
`define ERM_APP_STAT_HI 12'h131
`define ERM_EEP_CMD_LO 12'h502
`define ERM_EEP_CMD_HI 12'h503
`define ERM_WD_STAT_LO 12'h440
`define ERM_WD_STAT_HI 12'h441
`define ERM_SECOND_SYNC_PULSE_STAT 12'h98e
`define ERM_SYNC2_STAT 12'h98f
`define ERM_LATCH_STAT_LO 12'h9ae
`define ERM_LATCH_STAT_HI 12'h9af
`define ERM_CHAN_BASE_HI 5'h10
`define ERM_CHAN_ACT_OFS 3'h6

// net event request fields
`define ERM_NB_LATCH 0
`define ERM_NB_LINK 2
`define ERM_NB_APPST 3
`define ERM_NB_CHAN 4

// app event request fields
`define ERM_AB_CTRL 0
`define ERM_AB_LATCH 1
`define ERM_AB_SECOND_SYNC_PULSE 2
`define ERM_AB_SYNC2 3
`define ERM_AB_ACT 4
`define ERM_AB_EEP 5
`define ERM_AB_WD 6
`define ERM_AB_CHAN 8

// configuration bit positions
`define ERM_EMUL_BIT 8
`define ERM_SECOND_SYNC_PULSE_MAP_BIT 3
`define ERM_SYNC2_MAP_BIT 7

// reset values
`define ERM_APP_MASK_RST 32'h0000_0000
`define ERM_NET_MASK_RST 16'h0000

`endif

/* File: common/erm_pkg.sv */
// Purpose: shared types of the event request and mask block
// Assumes: nothing beyond the cfg header
// Notes: widths fixed at the documented values
package erm_pkg;
  typedef logic [11:0] erm_addr_t;
  typedef logic [31:0] erm_word_t;
  typedef logic [15:0] erm_half_t;
  typedef logic [3:0] erm_be_t;
endpackage

/* File: src/erm_top.sv */
// Purpose: event request registers, masks and local interrupt line
// Assumes: sources run on clk_sys; latch pins are asynchronous
// Notes: read data appears one cycle after the read strobe
// Contract
// - 32-bit app mask routes each app request bit to the interrupt line.
// - app mask written only by local host port; network side reads it.
// - net bit 0 sets on latch input change while latch is not locally controlled, clears on network latch-time read.
// - net bit 2 sets on link-layer status change, clears on network read.
// - net bit 3 sets on app-layer status change, clears on network read.
// - net bits 11:4 mirror pending events of buffer channels 0 to 7.
// - net bits 1 and 15:12 read zero; register read-only from local port.
// - app bit 0 sets on network control write, clears on local control read.
// - control write event only while local host emulation bit is zero.
// - app bit 1 flags latch change when latch is locally controlled.
// - app bit 2 follows first sync when config bit 3 set; cleared by read.
// - app bit 3 follows second sync when config bit 7 set; cleared by read.
// - app bit 4 sets on channel activation change, clears on local read.
// - app bit 5 flags pending EEPROM command until local acknowledge.
// - app bit 6 sets on watchdog expiry, clears on local status read.
// - app bits 23:8 flag interrupts of buffer channels 0 to 15.
// - app bits 7 and 31:24 read zero; register read-only on both sides.
// - 16-bit net mask selects net request bits for the frame event field.
// - sync states drive app bits 2 and 3 only when enabled.
`timescale 1ns/1ps
`include "erm_cfg.svh"

module erm_top
  import erm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // network side register access
  input wire erm_addr_t ns_addr,
  input wire logic ns_rd,
  input wire logic ns_wr,
  input wire erm_be_t ns_be,
  input wire erm_word_t ns_wdata,
  output erm_word_t ns_rdata,
  // local host port register access
  input wire erm_addr_t lh_addr,
  input wire logic lh_rd,
  input wire logic lh_wr,
  input wire erm_be_t lh_be,
  input wire erm_word_t lh_wdata,
  output erm_word_t lh_rdata,
  // configuration from neighbouring units
  input wire erm_half_t local_port_ctrl,
  input wire logic [7:0] sync_latch_cfg,
  input wire logic latch_local_ctrl,
  // latch pins, asynchronous
  input wire logic [1:0] latch_pin,
  // event sources on clk_sys
  input wire logic link_status_chg,
  input wire logic app_status_chg,
  input wire logic first_sync_state,
  input wire logic second_sync_state,
  input wire logic chan_act_chg,
  input wire logic eeprom_cmd_pending,
  input wire logic pd_wd_expired,
  input wire logic [7:0] chan_event_pending,
  input wire erm_half_t chan_irq_pending,
  // outputs
  output erm_half_t net_event_field,
  output logic local_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input erm_addr_t a, input erm_addr_t lo,
                                    input erm_addr_t hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic word_hit(input erm_addr_t a, input erm_addr_t ofs);
    word_hit = (a[11:2] == ofs[11:2]);
  endfunction

  function automatic erm_word_t be_merge(input erm_word_t old, input erm_word_t wd,
                                         input erm_be_t be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // latch pin synchroniser and change detect

  logic [1:0] latch_s1_r;
  logic [1:0] latch_s2_r;
  logic [1:0] latch_s3_r;
  logic latch_chg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      latch_s1_r <= 2'h0;
      latch_s2_r <= 2'h0;
      latch_s3_r <= 2'h0;
    end else begin
      latch_s1_r <= latch_pin;
      latch_s2_r <= latch_s1_r;
      latch_s3_r <= latch_s2_r;
    end
  end

  // only the second and third stages feed logic
  assign latch_chg = |(latch_s2_r ^ latch_s3_r);

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic ns_rd_latch;
  logic ns_rd_link;
  logic ns_rd_appst;
  logic ns_wr_ctrl;
  logic lh_rd_ctrl;
  logic lh_rd_latch;
  logic lh_rd_second_sync_pulse;
  logic lh_rd_sync2;
  logic lh_rd_act;
  logic lh_wr_eep;
  logic lh_rd_wd;

  assign ns_rd_latch = ns_rd && in_range(ns_addr, `ERM_LATCH_STAT_LO, `ERM_LATCH_STAT_HI);
  assign ns_rd_link = ns_rd && in_range(ns_addr, `ERM_LINK_STAT_LO, `ERM_LINK_STAT_HI);
  assign ns_rd_appst = ns_rd && in_range(ns_addr, `ERM_APP_STAT_LO, `ERM_APP_STAT_HI);
  assign ns_wr_ctrl = ns_wr && in_range(ns_addr, `ERM_APP_CTRL_LO, `ERM_APP_CTRL_HI);
  assign lh_rd_ctrl = lh_rd && in_range(lh_addr, `ERM_APP_CTRL_LO, `ERM_APP_CTRL_HI);
  assign lh_rd_latch = lh_rd && in_range(lh_addr, `ERM_LATCH_STAT_LO, `ERM_LATCH_STAT_HI);
  assign lh_rd_second_sync_pulse = lh_rd && (lh_addr == `ERM_SECOND_SYNC_PULSE_STAT);
  assign lh_rd_sync2 = lh_rd && (lh_addr == `ERM_SYNC2_STAT);
  // activation byte of every channel, 8 bytes apart from 0x800
  assign lh_rd_act = lh_rd && (lh_addr[11:7] == `ERM_CHAN_BASE_HI)
                     && (lh_addr[2:0] == `ERM_CHAN_ACT_OFS);
  assign lh_wr_eep = lh_wr && in_range(lh_addr, `ERM_EEP_CMD_LO, `ERM_EEP_CMD_HI);
  assign lh_rd_wd = lh_rd && in_range(lh_addr, `ERM_WD_STAT_LO, `ERM_WD_STAT_HI);

  ////////////////////////////////////////////////////////////////////////////
  // mask registers

  erm_word_t app_event_mask_r;
  erm_half_t net_event_mask_r;

  // only the local port writes the app mask; network writes there are dropped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_event_mask_r <= `ERM_APP_MASK_RST;
    end else if (lh_wr && word_hit(lh_addr, `ERM_APP_MASK_OFS)) begin
      app_event_mask_r <= be_merge(app_event_mask_r, lh_wdata, lh_be);
    end
  end

  // the net mask is the mirror case: network writes, local port reads
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_event_mask_r <= `ERM_NET_MASK_RST;
    end else if (ns_wr && word_hit(ns_addr, `ERM_NET_MASK_OFS)) begin
      net_event_mask_r <= erm_half_t'(be_merge({16'h0000, net_event_mask_r}, ns_wdata, ns_be));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // network event request flags; set wins over a clear in the same cycle

  logic net_latch_r;
  logic net_link_r;
  logic net_appst_r;
  erm_half_t net_event_request;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_latch_r <= 1'b0;
    end else if (latch_chg && !latch_local_ctrl) begin
      net_latch_r <= 1'b1;
    end else if (ns_rd_latch) begin
      net_latch_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_link_r <= 1'b0;
    end else if (link_status_chg) begin
      net_link_r <= 1'b1;
    end else if (ns_rd_link) begin
      net_link_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_appst_r <= 1'b0;
    end else if (app_status_chg) begin
      net_appst_r <= 1'b1;
    end else if (ns_rd_appst) begin
      net_appst_r <= 1'b0;
    end
  end

  always_comb begin
    net_event_request = 16'h0000;
    net_event_request[`ERM_NB_LATCH] = net_latch_r;
    net_event_request[`ERM_NB_LINK] = net_link_r;
    net_event_request[`ERM_NB_APPST] = net_appst_r;
    net_event_request[`ERM_NB_CHAN +: 8] = chan_event_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // application event request flags

  logic app_ctrl_r;
  logic app_latch_r;
  logic app_second_sync_pulse_r;
  logic app_sync2_r;
  logic app_act_r;
  logic app_eep_r;
  logic eep_pend_d_r;
  logic app_wd_r;
  erm_word_t app_event_request;

  // emulation mode loops the control register to status, so no event then
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_ctrl_r <= 1'b0;
    end else if (ns_wr_ctrl && !local_port_ctrl[`ERM_EMUL_BIT]) begin
      app_ctrl_r <= 1'b1;
    end else if (lh_rd_ctrl) begin
      app_ctrl_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_latch_r <= 1'b0;
    end else if (latch_chg && latch_local_ctrl) begin
      app_latch_r <= 1'b1;
    end else if (lh_rd_latch) begin
      app_latch_r <= 1'b0;
    end
  end

  // sync flags are sticky: a short pulse is not lost before the host reads
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_second_sync_pulse_r <= 1'b0;
    end else if (first_sync_state && sync_latch_cfg[`ERM_SECOND_SYNC_PULSE_MAP_BIT]) begin
      app_second_sync_pulse_r <= 1'b1;
    end else if (lh_rd_second_sync_pulse) begin
      app_second_sync_pulse_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_sync2_r <= 1'b0;
    end else if (second_sync_state && sync_latch_cfg[`ERM_SYNC2_MAP_BIT]) begin
      app_sync2_r <= 1'b1;
    end else if (lh_rd_sync2) begin
      app_sync2_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_act_r <= 1'b0;
    end else if (chan_act_chg) begin
      app_act_r <= 1'b1;
    end else if (lh_rd_act) begin
      app_act_r <= 1'b0;
    end
  end

  // a new command is its rising edge; a level would re-set after the ack
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      eep_pend_d_r <= 1'b0;
      app_eep_r <= 1'b0;
    end else begin
      eep_pend_d_r <= eeprom_cmd_pending;
      if (eeprom_cmd_pending && !eep_pend_d_r) begin
        app_eep_r <= 1'b1;
      end else if (lh_wr_eep) begin
        app_eep_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      app_wd_r <= 1'b0;
    end else if (pd_wd_expired) begin
      app_wd_r <= 1'b1;
    end else if (lh_rd_wd) begin
      app_wd_r <= 1'b0;
    end
  end

  always_comb begin
    app_event_request = 32'h0000_0000;
    app_event_request[`ERM_AB_CTRL] = app_ctrl_r;
    app_event_request[`ERM_AB_LATCH] = app_latch_r;
    app_event_request[`ERM_AB_SECOND_SYNC_PULSE] = app_second_sync_pulse_r;
    app_event_request[`ERM_AB_SYNC2] = app_sync2_r;
    app_event_request[`ERM_AB_ACT] = app_act_r;
    app_event_request[`ERM_AB_EEP] = app_eep_r;
    app_event_request[`ERM_AB_WD] = app_wd_r;
    app_event_request[`ERM_AB_CHAN +: 16] = chan_irq_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // one cycle behind the flags, in exchange for a glitch-free line
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      local_irq <= 1'b0;
    end else begin
      local_irq <= |(app_event_request & app_event_mask_r);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      net_event_field <= 16'h0000;
    end else begin
      net_event_field <= net_event_request & net_event_mask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data; request registers ignore writes from either side

  // both ports see the same map, so one decoder serves them
  function automatic erm_word_t reg_read(input erm_addr_t a);
    if (word_hit(a, `ERM_NET_MASK_OFS)) begin
      reg_read = {16'h0000, net_event_mask_r};
    end else if (word_hit(a, `ERM_APP_MASK_OFS)) begin
      reg_read = app_event_mask_r;
    end else if (word_hit(a, `ERM_NET_REQ_OFS)) begin
      reg_read = {16'h0000, net_event_request};
    end else if (word_hit(a, `ERM_APP_REQ_OFS)) begin
      reg_read = app_event_request;
    end else begin
      reg_read = 32'h0000_0000;
    end
  endfunction

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ns_rdata <= 32'h0000_0000;
    end else if (ns_rd) begin
      ns_rdata <= reg_read(ns_addr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lh_rdata <= 32'h0000_0000;
    end else if (lh_rd) begin
      lh_rdata <= reg_read(lh_addr);
    end
  end

endmodule

/* File: tb/erm_top_sva.sv */
// Purpose: port-level checks of the event request and mask block
// Assumes: masks reset to zero and change only through writes seen here
// Notes: masks are shadowed from write strobes, never read back from the design
`timescale 1ns/1ps
module erm_chk
  import erm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // network side
  input wire erm_addr_t ns_addr,
  input wire logic ns_rd,
  input wire logic ns_wr,
  input wire erm_be_t ns_be,
  input wire erm_word_t ns_wdata,
  input wire erm_word_t ns_rdata,
  // local host port
  input wire erm_addr_t lh_addr,
  input wire logic lh_rd,
  input wire logic lh_wr,
  input wire erm_be_t lh_be,
  input wire erm_word_t lh_wdata,
  input wire erm_word_t lh_rdata,
  // sources and outputs
  input wire erm_half_t local_port_ctrl,
  input wire logic link_status_chg,
  input wire logic pd_wd_expired,
  input wire logic [7:0] chan_event_pending,
  input wire erm_half_t net_event_field,
  input wire logic local_irq
);
  erm_word_t amask_r;
  erm_half_t nmask_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      amask_r <= '0;
    end else if (lh_wr && lh_addr[11:2] == 10'h081) begin
      for (int i = 0; i < 4; i++) begin
        if (lh_be[i]) begin
          amask_r[8*i+:8] <= lh_wdata[8*i+:8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nmask_r <= '0;
    end else if (ns_wr && ns_addr[11:2] == 10'h080) begin
      for (int i = 0; i < 2; i++) begin
        if (ns_be[i]) begin
          nmask_r[8*i+:8] <= ns_wdata[8*i+:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_irq_masked:
    assert property (amask_r == 32'h0 && $past(amask_r) == 32'h0 |-> !local_irq)
    else $error("local_irq high while every event is masked");
  a_link_field:
    assert property (link_status_chg && nmask_r[2] ##1 nmask_r[2] |-> ##1 net_event_field[2])
    else $error("link status event missing from event field");
  a_wd_irq:
    assert property (pd_wd_expired && amask_r[6] ##1 amask_r[6] |-> ##1 local_irq)
    else $error("watchdog expiry did not raise local_irq");
  a_ctrl_irq:
    assert property (ns_wr && ns_addr[11:1] == 11'h090 && !local_port_ctrl[8] && amask_r[0]
      ##1 amask_r[0] |-> ##1 local_irq)
    else $error("control write did not raise local_irq");
  a_chan_mirror:
    assert property (($stable(chan_event_pending) && $stable(nmask_r))[*3]
      |-> net_event_field[11:4] == (chan_event_pending & nmask_r[11:4]))
    else $error("channel pending bits not mirrored");
  a_net_resv:
    assert property (net_event_field[15:12] == 4'h0 && !net_event_field[1])
    else $error("reserved event field bit set");
  a_mask_ns_read:
    assert property (ns_rd && ns_addr[11:2] == 10'h081 |=> ns_rdata == $past(amask_r))
    else $error("network read of app mask wrong");
  a_app_resv:
    assert property (lh_rd && lh_addr[11:2] == 10'h088 |=> lh_rdata[31:24] == 8'h00 && !lh_rdata[7])
    else $error("reserved app request bit set");
endmodule

bind erm_top erm_chk u_chk (.clk_sys, .rst_b, .ns_addr, .ns_rd, .ns_wr, .ns_be, .ns_wdata,
  .ns_rdata, .lh_addr, .lh_rd, .lh_wr, .lh_be, .lh_wdata, .lh_rdata, .local_port_ctrl,
  .link_status_chg, .pd_wd_expired, .chan_event_pending, .net_event_field, .local_irq);

/* File: tb/erm_host_model.sv */
// Purpose: local host processor on the local host port
// Assumes: read data is valid one cycle after the strobe
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module erm_host_model
  import erm_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // local host port
  output erm_addr_t lh_addr,
  output logic lh_rd,
  output logic lh_wr,
  output erm_be_t lh_be,
  output erm_word_t lh_wdata,
  input wire erm_word_t lh_rdata
);
  initial begin
    lh_addr = '0;
    lh_rd = 1'b0;
    lh_wr = 1'b0;
    lh_be = '0;
    lh_wdata = '0;
  end

  ////////////////////////////////////////////////////////////
  // the only writer of the app mask
  task automatic wr(input erm_addr_t a, input erm_word_t d);
    @(negedge clk_sys);
    lh_addr = a;
    lh_be = 4'hf;
    lh_wdata = d;
    lh_wr = 1'b1;
    @(negedge clk_sys);
    lh_wr = 1'b0;
    lh_addr = ~a;
    lh_be = 4'h0;
    lh_wdata = ~d;
  endtask

  task automatic rd(input erm_addr_t a, output erm_word_t d);
    @(negedge clk_sys);
    lh_addr = a;
    lh_rd = 1'b1;
    @(negedge clk_sys);
    lh_rd = 1'b0;
    lh_addr = ~a;
    d = lh_rdata;
  endtask
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the event request and mask block
// Assumes: 40 MHz clock, inputs change at the falling edge
// Notes: latch waits cover the three-flop pin synchroniser
`timescale 1ns/1ps
`include "erm_cfg.svh"
module tb;
  import erm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  erm_addr_t ns_addr = '0;
  logic ns_rd = 1'b0;
  logic ns_wr = 1'b0;
  erm_be_t ns_be = '0;
  erm_word_t ns_wdata = '0;
  erm_word_t ns_rdata, lh_rdata, lh_wdata;
  erm_addr_t lh_addr;
  logic lh_rd, lh_wr, local_irq;
  erm_be_t lh_be;
  erm_half_t local_port_ctrl = '0;
  erm_half_t chan_irq_pending = '0;
  erm_half_t net_event_field;
  logic [7:0] sync_latch_cfg = '0;
  logic [7:0] chan_event_pending = '0;
  logic [1:0] latch_pin = '0;
  logic latch_local_ctrl = 1'b0, link_status_chg = 1'b0, app_status_chg = 1'b0;
  logic first_sync_state = 1'b0, second_sync_state = 1'b0, chan_act_chg = 1'b0;
  logic eeprom_cmd_pending = 1'b0, pd_wd_expired = 1'b0;
  int fails = 0;
  int samples_checked = 0;
  // sync status reads act as the acknowledge
  erm_addr_t clr [7] = '{`ERM_APP_CTRL_LO, `ERM_LATCH_STAT_LO, `ERM_SECOND_SYNC_PULSE_STAT,
    `ERM_SYNC2_STAT, 12'h806, `ERM_EEP_CMD_LO, `ERM_WD_STAT_LO};

  always #12.5 clk_sys = ~clk_sys;

  erm_top dut (.clk_sys, .rst_b, .ns_addr, .ns_rd, .ns_wr, .ns_be, .ns_wdata, .ns_rdata,
    .lh_addr, .lh_rd, .lh_wr, .lh_be, .lh_wdata, .lh_rdata, .local_port_ctrl, .sync_latch_cfg,
    .latch_local_ctrl, .latch_pin, .link_status_chg, .app_status_chg, .first_sync_state,
    .second_sync_state, .chan_act_chg, .eeprom_cmd_pending, .pd_wd_expired,
    .chan_event_pending, .chan_irq_pending, .net_event_field, .local_irq);
  erm_host_model host (.clk_sys, .lh_addr, .lh_rd, .lh_wr, .lh_be, .lh_wdata, .lh_rdata);

  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input erm_word_t e, input erm_word_t g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic nsw(input erm_addr_t a, input erm_word_t d);
    @(negedge clk_sys);
    ns_addr = a;
    ns_be = 4'hf;
    ns_wdata = d;
    ns_wr = 1'b1;
    @(negedge clk_sys);
    ns_wr = 1'b0;
    ns_addr = ~a;
    ns_wdata = ~d;
  endtask

  task automatic nsr(input erm_addr_t a, output erm_word_t d);
    @(negedge clk_sys);
    ns_addr = a;
    ns_rd = 1'b1;
    @(negedge clk_sys);
    ns_rd = 1'b0;
    ns_addr = ~a;
    d = ns_rdata;
  endtask

  task automatic t_regs();
    erm_word_t d;
    nsr(`ERM_APP_MASK_OFS, d);
    chk("mask_rst", 32'h0, d);
    nsr(12'hffc, d);
    chk("unmapped", 32'h0, d);
    host.wr(`ERM_APP_MASK_OFS, 32'h1234_5678);
    nsw(`ERM_APP_MASK_OFS, 32'hffff_ffff);
    nsr(`ERM_APP_MASK_OFS, d);
    chk("mask_rw", 32'h1234_5678, d);
  endtask

  task automatic t_net_evt();
    erm_word_t d;
    nsw(`ERM_NET_MASK_OFS, 32'hffff);
    latch_pin = 2'h2;
    link_status_chg = 1'b1;
    app_status_chg = 1'b1;
    @(negedge clk_sys);
    link_status_chg = 1'b0;
    app_status_chg = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("net_field", 32'h000d, {16'h0, net_event_field});
    nsr(`ERM_NET_REQ_OFS, d);
    chk("net_req", 32'h000d, d);
    nsw(`ERM_NET_MASK_OFS, 32'h0004);
    @(negedge clk_sys);
    chk("net_field_mask", 32'h0004, {16'h0, net_event_field});
    nsr(`ERM_LINK_STAT_LO, d);
    nsr(`ERM_NET_REQ_OFS, d);
    chk("net_link_clr", 32'h0009, d);
    nsr(`ERM_APP_STAT_LO, d);
    nsr(`ERM_LATCH_STAT_LO, d);
    host.rd(`ERM_NET_REQ_OFS, d);
    chk("net_clr", 32'h0, d);
  endtask

  task automatic t_mirror();
    erm_word_t d;
    chan_event_pending = 8'ha5;
    chan_irq_pending = 16'h8001;
    host.wr(`ERM_APP_REQ_OFS, 32'hffff_ffff);
    host.wr(`ERM_APP_MASK_OFS, 32'h0000_0100);
    repeat (2) @(negedge clk_sys);
    chk("irq_chan", 32'h1, {31'h0, local_irq});
    host.rd(`ERM_APP_REQ_OFS, d);
    chk("app_chan", 32'h0080_0100, d);
    host.rd(`ERM_NET_REQ_OFS, d);
    chk("net_chan", 32'h0000_0a50, d);
    host.wr(`ERM_APP_MASK_OFS, 32'hff00_00ff);
    repeat (2) @(negedge clk_sys);
    chk("irq_off", 32'h0, {31'h0, local_irq});
    chan_event_pending = 8'h00;
    chan_irq_pending = 16'h0000;
  endtask

  task automatic t_app_evt(input int b);
    erm_word_t d;
    host.wr(`ERM_APP_MASK_OFS, 32'h1 << b);
    sync_latch_cfg = (b == 2) ? 8'h80 : 8'h88;
    case (b)
      0: begin
        local_port_ctrl = 16'h0100;
        nsw(`ERM_APP_CTRL_LO, 32'h0);
        repeat (3) @(negedge clk_sys);
        chk("irq_emul", 32'h0, {31'h0, local_irq});
        local_port_ctrl = 16'h0000;
        nsw(`ERM_APP_CTRL_LO, 32'h0);
      end
      1: begin
        latch_local_ctrl = 1'b1;
        latch_pin = ~latch_pin;
      end
      2: begin
        first_sync_state = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("sync_unmapped", 32'h0, {31'h0, local_irq});
        sync_latch_cfg = 8'h88;
      end
      3: second_sync_state = 1'b1;
      4: chan_act_chg = 1'b1;
      5: eeprom_cmd_pending = 1'b1;
      default: pd_wd_expired = 1'b1;
    endcase
    @(negedge clk_sys);
    chan_act_chg = 1'b0;
    pd_wd_expired = 1'b0;
    first_sync_state = 1'b0;
    second_sync_state = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("irq_set", 32'h1, {31'h0, local_irq});
    host.rd(`ERM_APP_REQ_OFS, d);
    chk("app_req", 32'h1 << b, d);
    if (b == 1) begin
      host.rd(`ERM_NET_REQ_OFS, d);
      chk("net_latch_local", 32'h0, d);
    end
    if (b == 5) begin
      host.wr(clr[b], 32'h0);
    end else begin
      host.rd(clr[b], d);
    end
    repeat (3) @(negedge clk_sys);
    chk("irq_clr", 32'h0, {31'h0, local_irq});
    eeprom_cmd_pending = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    t_regs();
    t_net_evt();
    t_mirror();
    for (int b = 0; b < 7; b++) begin
      t_app_evt(b);
    end
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end
endmodule
